// ---- src/icc_pkg.sv ----
/*
 * icc_pkg: offsets, field positions, reset values and bus codes for the
 * interrupt global configuration block.
 * assumes: a 32-bit AHB-Lite slave port, word-aligned registers.
 */
package icc_pkg;

    // register byte offsets
    localparam logic [31:0] ICC_OFF_CTRL   = 32'h0000_0000;
    localparam logic [31:0] ICC_OFF_STATUS = 32'h0000_0004;
    localparam logic [31:0] ICC_OFF_MASK   = 32'h0000_0008;

    // control register field layout
    localparam int          ICC_NUM_EXT    = 5;
    localparam int          ICC_VECTOR_MODE_SELECT_BIT   = 12;
    localparam int          ICC_TPC_LSB    = 8;
    localparam int          ICC_TPC_W      = 3;
    localparam int          ICC_EP_LSB     = 0;
    localparam logic [31:0] ICC_CTRL_IMPL  = 32'h0000_171f;

    // reset values
    localparam logic [31:0] ICC_CTRL_RST   = 32'h0000_0000;
    localparam logic [4:0]  ICC_STATUS_RST = 5'h00;
    localparam logic [4:0]  ICC_MASK_RST   = 5'h00;

    // ahb codes
    localparam logic [1:0]  ICC_HTRANS_NSQ = 2'h2;
    localparam logic [1:0]  ICC_HTRANS_SEQ = 2'h3;
    localparam logic        ICC_HRESP_OKAY = 1'h0;

    typedef logic [ICC_TPC_W-1:0] icc_prio_t;

endpackage : icc_pkg

// ---- src/icc_bus_if.sv ----
/*
 * icc_bus_if: register access strobes between the bus slave and the
 * register file of the configuration block.
 * assumes: one clock; wr_en marks a write data phase for one cycle.
 */
`timescale 1ns/10ps
interface icc_bus_if;
    logic        wr_en;
    logic [31:0] addr;
    logic [31:0] wdata;
    logic [31:0] rdata;

    modport slv  (output wr_en, output addr, output wdata, input rdata);
    modport regs (input wr_en, input addr, input wdata, output rdata);
endinterface : icc_bus_if

// ---- src/icc_ext_edge.sv ----
/*
 * icc_ext_edge: synchroniser and selectable edge detector for the
 * external interrupt inputs.
 * assumes: pins may be asynchronous; pulse output is one cycle wide.
 */
`timescale 1ns/10ps
module icc_ext_edge
    import icc_pkg::*;
#(
    parameter int N = ICC_NUM_EXT
) (
    input  wire logic         hclk,
    input  wire logic         hresetn,
    input  wire logic [N-1:0] pin,
    input  wire logic [N-1:0] rise_sel,
    output logic      [N-1:0] det
);
    logic [N-1:0] sync1_r, sync2_r, last_r, det_r;
    logic [N-1:0] det_nxt;

    // RULE5 polarity selects edge
    // RULE7 one pulse per edge
    always_comb begin
        det_nxt = (rise_sel & sync2_r & ~last_r) | (~rise_sel & ~sync2_r & last_r);
    end

    // RULE7 two-flop synchroniser
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sync1_r <= '0;
            sync2_r <= '0;
            last_r  <= '0;
            det_r   <= '0;
        end else begin
            sync1_r <= pin;
            sync2_r <= sync1_r;
            last_r  <= sync2_r;
            det_r   <= det_nxt;
        end
    end

    assign det = det_r;
endmodule : icc_ext_edge

// ---- src/icc_ahb_slave.sv ----
/*
 * icc_ahb_slave: AHB-Lite slave front end; writes complete with no wait,
 * reads take one wait state so read data come from a flip-flop.
 * assumes: single word transfers; response always OKAY.
 */
`timescale 1ns/10ps
module icc_ahb_slave
    import icc_pkg::*;
(
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic [31:0]      hrdata,
    output logic             hresp,
    icc_bus_if.slv           bus
);
    typedef enum logic [1:0] {ICC_S_IDLE, ICC_S_WRITE, ICC_S_RWAIT, ICC_S_RDONE} icc_state_t;

    icc_state_t  state_r, state_nxt;
    logic [31:0] addr_r, addr_nxt, rdata_r, rdata_nxt;
    logic        take;

    always_comb begin
        take      = hsel && hready && (htrans == ICC_HTRANS_NSQ || htrans == ICC_HTRANS_SEQ);
        state_nxt = state_r;
        addr_nxt  = addr_r;
        rdata_nxt = rdata_r;
        unique case (state_r)
            ICC_S_RWAIT: begin
                rdata_nxt = bus.rdata;
                state_nxt = ICC_S_RDONE;
            end
            ICC_S_IDLE, ICC_S_WRITE, ICC_S_RDONE: begin
                state_nxt = ICC_S_IDLE;
                if (take) begin
                    addr_nxt  = haddr;
                    state_nxt = hwrite ? ICC_S_WRITE : ICC_S_RWAIT;
                end
            end
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_r <= ICC_S_IDLE;
            addr_r  <= '0;
            rdata_r <= '0;
        end else begin
            state_r <= state_nxt;
            addr_r  <= addr_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    assign hreadyout = (state_r != ICC_S_RWAIT);
    assign hrdata    = rdata_r;
    assign hresp     = ICC_HRESP_OKAY;
    assign bus.wr_en = (state_r == ICC_S_WRITE);
    assign bus.addr  = addr_r;
    assign bus.wdata = hwdata;
endmodule : icc_ahb_slave

// ---- src/icc_top.sv ----
/*
 * icc_top: global configuration of the interrupt controller: vector mode,
 * proximity timer threshold, external input edge polarity, edge event
 * status with mask and one level interrupt.
 * assumes: AHB-Lite register access; priority requests valid one cycle.
 */
// Behaviour
// RULE1 - control bit 12 set selects multi-vectored mode, cleared selects single-vectored.
// RULE2 - threshold N of 2 to 7 lets priority N or lower start proximity timer.
// RULE3 - threshold of one lets only priority 1 start the proximity timer.
// RULE4 - threshold of zero keeps the proximity timer disabled for all interrupts.
// RULE5 - bits 4 to 0 pick rising (set) or falling (clear) edge per input.
// RULE6 - unimplemented control bits ignore writes and read back zero.
// RULE7 - inputs synchronised; each selected edge gives exactly one pending pulse.
`timescale 1ns/10ps
module icc_top
    import icc_pkg::*;
(
    input  wire logic                   hclk,
    input  wire logic                   hresetn,
    input  wire logic                   hsel,
    input  wire logic [31:0]            haddr,
    input  wire logic [1:0]             htrans,
    input  wire logic                   hwrite,
    input  wire logic [2:0]             hsize,
    input  wire logic [31:0]            hwdata,
    input  wire logic                   hready,
    output logic                        hreadyout,
    output logic [31:0]                 hrdata,
    output logic                        hresp,
    input  wire logic [ICC_NUM_EXT-1:0] ext_irq_in,
    output logic [ICC_NUM_EXT-1:0]      ext_irq_pend,
    input  wire logic                   irq_req_valid,
    input  wire icc_prio_t              irq_req_prio,
    output logic                        prox_timer_start,
    output logic                        vector_mode_select,
    output logic                        irq
);
    icc_bus_if bus ();

    logic [31:0]            interrupt_global_control_r, interrupt_global_control_nxt;
    logic [ICC_NUM_EXT-1:0] status_r, status_nxt;
    logic [ICC_NUM_EXT-1:0] mask_r, mask_nxt;
    logic                   irq_r, irq_nxt;
    logic                   prox_r, prox_nxt;
    logic [31:0]            rdata;
    logic [ICC_NUM_EXT-1:0] ext_det;
    logic [ICC_NUM_EXT-1:0] ext_edge_sel;
    logic [ICC_NUM_EXT-1:0] w1c;
    icc_prio_t              proximity_priority_threshold;

    function automatic logic prox_hit(input icc_prio_t thr, input icc_prio_t prio);
        // zero threshold disables; priority zero never requests
        prox_hit = (thr != '0) && (prio != '0) && (prio <= thr);
    endfunction : prox_hit

    icc_ahb_slave u_slave (
        .hclk      (hclk),
        .hresetn   (hresetn),
        .hsel      (hsel),
        .haddr     (haddr),
        .htrans    (htrans),
        .hwrite    (hwrite),
        .hwdata    (hwdata),
        .hready    (hready),
        .hreadyout (hreadyout),
        .hrdata    (hrdata),
        .hresp     (hresp),
        .bus       (bus.slv)
    );

    icc_ext_edge #(.N(ICC_NUM_EXT)) u_edge (
        .hclk     (hclk),
        .hresetn  (hresetn),
        .pin      (ext_irq_in),
        .rise_sel (ext_edge_sel),
        .det      (ext_det)
    );

    assign proximity_priority_threshold =
        interrupt_global_control_r[ICC_TPC_LSB +: ICC_TPC_W];
    // RULE5 per-input edge select
    assign ext_edge_sel = interrupt_global_control_r[ICC_EP_LSB +: ICC_NUM_EXT];

    // register read mux
    always_comb begin
        rdata = '0;
        if (bus.addr == ICC_OFF_CTRL) begin
            rdata = interrupt_global_control_r;
        end else if (bus.addr == ICC_OFF_STATUS) begin
            rdata[ICC_NUM_EXT-1:0] = status_r;
        end else if (bus.addr == ICC_OFF_MASK) begin
            rdata[ICC_NUM_EXT-1:0] = mask_r;
        end
    end
    assign bus.rdata = rdata;

    // register writes, status and interrupt
    always_comb begin
        interrupt_global_control_nxt = interrupt_global_control_r;
        mask_nxt = mask_r;
        w1c      = '0;
        if (bus.wr_en && bus.addr == ICC_OFF_CTRL) begin
            // RULE6 reserved bits dropped
            interrupt_global_control_nxt = bus.wdata & ICC_CTRL_IMPL;
        end
        if (bus.wr_en && bus.addr == ICC_OFF_MASK) begin
            mask_nxt = bus.wdata[ICC_NUM_EXT-1:0];
        end
        if (bus.wr_en && bus.addr == ICC_OFF_STATUS) begin
            w1c = bus.wdata[ICC_NUM_EXT-1:0];
        end
        // RULE7 new edge wins over clear
        status_nxt = (status_r & ~w1c) | ext_det;
        irq_nxt    = |(status_nxt & mask_nxt);
    end

    // proximity timer start request
    always_comb begin
        // RULE2 threshold compare
        // RULE3 only priority one
        // RULE4 zero disables
        prox_nxt = irq_req_valid && prox_hit(proximity_priority_threshold, irq_req_prio);
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            interrupt_global_control_r <= ICC_CTRL_RST;
            status_r <= ICC_STATUS_RST;
            mask_r   <= ICC_MASK_RST;
            irq_r    <= 1'b0;
            prox_r   <= 1'b0;
        end else begin
            interrupt_global_control_r <= interrupt_global_control_nxt;
            status_r <= status_nxt;
            mask_r   <= mask_nxt;
            irq_r    <= irq_nxt;
            prox_r   <= prox_nxt;
        end
    end

    // RULE1 vector mode output
    assign vector_mode_select = interrupt_global_control_r[ICC_VECTOR_MODE_SELECT_BIT];
    assign prox_timer_start   = prox_r;
    assign ext_irq_pend       = ext_det;
    assign irq                = irq_r;

    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    AST_VECTOR_MODE_SELECT_WRITE: assert property ( // RULE1
        (bus.wr_en && bus.addr == ICC_OFF_CTRL)
        |=> (vector_mode_select == $past(bus.wdata[ICC_VECTOR_MODE_SELECT_BIT])))
        else $error("vector mode does not follow written bit");

    AST_PROX_RANGE: assert property ( // RULE2
        (irq_req_valid && proximity_priority_threshold >= 3'h2
         && irq_req_prio != 3'h0 && irq_req_prio <= proximity_priority_threshold)
        |=> prox_timer_start)
        else $error("eligible priority did not start proximity timer");

    AST_PROX_ABOVE: assert property ( // RULE2
        (irq_req_valid && irq_req_prio > proximity_priority_threshold)
        |=> !prox_timer_start)
        else $error("priority above threshold started proximity timer");

    AST_PROX_ONE: assert property ( // RULE3
        (proximity_priority_threshold == 3'h1 && irq_req_valid)
        |=> (prox_timer_start == ($past(irq_req_prio) == 3'h1)))
        else $error("threshold one mishandled");

    AST_PROX_OFF: assert property ( // RULE4
        (proximity_priority_threshold == 3'h0) |=> !prox_timer_start)
        else $error("proximity timer started while disabled");

    AST_RISE_EDGE: assert property ( // RULE5
        ($rose(ext_irq_in[0]) && ext_edge_sel[0])
        ##1 (ext_irq_in[0] && ext_edge_sel[0]) [*2]
        |=> ext_irq_pend[0])
        else $error("rising edge not detected");

    AST_FALL_EDGE: assert property ( // RULE5
        ($fell(ext_irq_in[1]) && !ext_edge_sel[1])
        ##1 (!ext_irq_in[1] && !ext_edge_sel[1]) [*2]
        |=> ext_irq_pend[1])
        else $error("falling edge not detected");

    AST_RESERVED_ZERO: assert property ( // RULE6
        (bus.wr_en && bus.addr == ICC_OFF_CTRL)
        |=> ((interrupt_global_control_r & ~ICC_CTRL_IMPL) == 32'h0000_0000))
        else $error("reserved control bits not zero");

    AST_PEND_STICKY: assert property ( // RULE7
        ext_irq_pend[2] |=> (status_r[2] && !ext_irq_pend[2]))
        else $error("pending pulse lost or repeated");

    AST_NO_LEVEL_REPEAT: assert property ( // RULE7
        ext_irq_pend[3] ##1 $stable(ext_irq_in[3]) [*4] |-> !ext_irq_pend[3])
        else $error("steady level gave a second request");

    AST_CTRL_HOLD: assert property ( // RULE1
        !(bus.wr_en && bus.addr == ICC_OFF_CTRL)
        |=> $stable(interrupt_global_control_r))
        else $error("control register changed without a write");

    AST_VECTOR_MODE_SELECT_READ: assert property ( // RULE1
        (bus.addr == ICC_OFF_CTRL)
        |-> (bus.rdata[ICC_VECTOR_MODE_SELECT_BIT] == vector_mode_select))
        else $error("vector mode read back differs from output");

    AST_TPC_WRITE: assert property ( // RULE2
        (bus.wr_en && bus.addr == ICC_OFF_CTRL)
        |=> (proximity_priority_threshold == $past(bus.wdata[ICC_TPC_LSB +: ICC_TPC_W])))
        else $error("threshold does not follow written field");

    AST_PROX_NEEDS_VALID: assert property ( // RULE2
        prox_timer_start
        |-> $past(irq_req_valid))
        else $error("proximity timer started without a request");

    AST_PROX_PRIO_ZERO: assert property ( // RULE2
        (irq_req_valid && irq_req_prio == 3'h0)
        |=> !prox_timer_start)
        else $error("priority zero started proximity timer");

    AST_PROX_TOP: assert property ( // RULE2
        (irq_req_valid && proximity_priority_threshold == 3'h7 && irq_req_prio != 3'h0)
        |=> prox_timer_start)
        else $error("threshold seven missed an eligible request");

    AST_PROX_ONE_HIGHER: assert property ( // RULE3
        (irq_req_valid && proximity_priority_threshold == 3'h1 && irq_req_prio > 3'h1)
        |=> !prox_timer_start)
        else $error("threshold one accepted a higher priority");

    AST_PROX_OFF_VALID: assert property ( // RULE4
        (irq_req_valid && proximity_priority_threshold == 3'h0)
        |=> !prox_timer_start)
        else $error("request started a disabled proximity timer");

    AST_POL_WRITE: assert property ( // RULE5
        (bus.wr_en && bus.addr == ICC_OFF_CTRL)
        |=> (ext_edge_sel == $past(bus.wdata[ICC_EP_LSB +: ICC_NUM_EXT])))
        else $error("edge select does not follow written bits");

    AST_RISE_IGNORE_FALL: assert property ( // RULE5
        ($fell(ext_irq_in[0]) && ext_edge_sel[0])
        ##1 (!ext_irq_in[0] && ext_edge_sel[0]) [*2]
        |=> !ext_irq_pend[0])
        else $error("falling edge seen with rising select");

    AST_FALL_IGNORE_RISE: assert property ( // RULE5
        ($rose(ext_irq_in[1]) && !ext_edge_sel[1])
        ##1 (ext_irq_in[1] && !ext_edge_sel[1]) [*2]
        |=> !ext_irq_pend[1])
        else $error("rising edge seen with falling select");

    AST_CTRL_RSVD_READ: assert property ( // RULE6
        (bus.addr == ICC_OFF_CTRL)
        |-> ((bus.rdata & ~ICC_CTRL_IMPL) == 32'h0000_0000))
        else $error("reserved control bits read back non-zero");

    AST_UNMAPPED_READ: assert property ( // RULE6
        (bus.addr != ICC_OFF_CTRL && bus.addr != ICC_OFF_STATUS && bus.addr != ICC_OFF_MASK)
        |-> (bus.rdata == 32'h0000_0000))
        else $error("unmapped address read back non-zero");

    AST_READ_WAIT: assert property ( // RULE6
        (hsel && hready && hreadyout && htrans == ICC_HTRANS_NSQ && !hwrite)
        |=> !hreadyout ##1 hreadyout)
        else $error("read did not take exactly one wait state");

    AST_STATUS_SET: assert property ( // RULE7
        (ext_irq_pend != 5'h00)
        |=> ((status_r & $past(ext_irq_pend)) == $past(ext_irq_pend)))
        else $error("pending pulse did not set status");

    AST_STATUS_W1C: assert property ( // RULE7
        (bus.wr_en && bus.addr == ICC_OFF_STATUS && bus.wdata[0] && !ext_irq_pend[0])
        |=> !status_r[0])
        else $error("write one did not clear status");

    AST_MASK_WRITE: assert property ( // RULE7
        (bus.wr_en && bus.addr == ICC_OFF_MASK)
        |=> (mask_r == $past(bus.wdata[ICC_NUM_EXT-1:0])))
        else $error("mask does not follow written bits");

    AST_IRQ_LEVEL: assert property ( // RULE7
        irq == (|(status_r & mask_r)))
        else $error("interrupt level differs from masked status");

    AST_PEND_ISOLATED: assert property ( // RULE7
        (ext_irq_pend != 5'h00)
        |=> ((ext_irq_pend & $past(ext_irq_pend)) == 5'h00))
        else $error("pending pulse longer than one cycle");

    COV_MULTI_VECTOR: cover property (
        (bus.wr_en && bus.addr == ICC_OFF_CTRL) ##1 vector_mode_select);
    COV_PROX_START: cover property (prox_timer_start && proximity_priority_threshold == 3'h7);
    COV_IRQ_CLEAR: cover property (irq ##[1:20] !irq);
    COV_EDGE_SEEN: cover property (ext_irq_pend[4]);
    COV_FALL_SEEN: cover property (ext_irq_pend[1] && !ext_edge_sel[1]);
endmodule : icc_top

// ---- tb/icc_far_end.sv ----
/*
 * icc_far_end: model of the core side request lines and the external pins.
 * assumes: caller enters its tasks at a rising edge of hclk.
 */
`timescale 1ns/10ps
module icc_far_end
    import icc_pkg::*;
(
    input  wire logic              hclk,
    output logic [ICC_NUM_EXT-1:0] pin,
    output logic                   req_valid,
    output icc_prio_t              req_prio
);
    initial begin
        pin       = '0;
        req_valid = 1'b0;
        req_prio  = '0;
    end

    task automatic set_pin(input int idx, input logic val);
        @(posedge hclk);
        pin[idx] <= val;
        repeat (6) @(posedge hclk);
    endtask : set_pin

    // one cycle request, prio scrambled after
    task automatic request(input icc_prio_t p);
        @(posedge hclk);
        req_valid <= 1'b1;
        req_prio  <= p;
        @(posedge hclk);
        req_valid <= 1'b0;
        req_prio  <= ~p;
    endtask : request
endmodule : icc_far_end

// ---- tb/testbench.sv ----
/*
 * testbench: self-checking bench for icc_top with an AHB-Lite master.
 * assumes: single slave, hready fed from hreadyout.
 */
`timescale 1ns/10ps
module testbench;
    import icc_pkg::*;
    logic                   hclk = 1'b0;
    logic                   hresetn = 1'b0;
    logic                   hsel = 1'b0;
    logic [31:0]            haddr = '0;
    logic [1:0]             htrans = '0;
    logic                   hwrite = 1'b0;
    logic [31:0]            hwdata = '0;
    logic                   hreadyout, hresp, prox_timer_start, vector_mode_select, irq;
    logic [31:0]            hrdata;
    logic [ICC_NUM_EXT-1:0] ext_irq_in, ext_irq_pend;
    logic                   irq_req_valid;
    icc_prio_t              irq_req_prio;
    int                     fails = 0;
    int                     checks = 0;
    int                     seed = 32'haac8;
    logic                   rd_pend = 1'b0;
    logic [31:0]            rq[$], pq[$];
    logic                   xq[$];

    always #5 hclk = ~hclk;

    icc_top dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
        .ext_irq_in(ext_irq_in), .ext_irq_pend(ext_irq_pend),
        .irq_req_valid(irq_req_valid), .irq_req_prio(irq_req_prio),
        .prox_timer_start(prox_timer_start), .vector_mode_select(vector_mode_select),
        .irq(irq));

    icc_far_end u_far (.hclk(hclk), .pin(ext_irq_in), .req_valid(irq_req_valid),
        .req_prio(irq_req_prio));

    task automatic cmp(input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e) begin
            fails++;
            $display("MISMATCH %0t word exp %h got %h", $time, e, g);
        end
    endtask : cmp

    task automatic cmp_bit(input logic e, input logic g);
        checks++;
        if (g !== e) begin
            fails++;
            $display("MISMATCH %0t flag exp %b got %b", $time, e, g);
        end
    endtask : cmp_bit

    task automatic results;
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : results

    // one single word transfer, read expectation noted
    task automatic bus(input logic w, input logic [31:0] a, d, e);
        if (!w) rq.push_back(e);
        hsel   <= 1'b1;
        haddr  <= a;
        htrans <= ICC_HTRANS_NSQ;
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= w ? d : ~d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
    endtask : bus

    // random polarity and mask, random pin toggles
    task automatic edges(input logic [31:0] c, input logic [4:0] m);
        int         i;
        logic       v;
        logic [4:0] st;
        st = '0;
        bus(1, ICC_OFF_CTRL, c, 0);
        bus(1, ICC_OFF_MASK, {27'h0, m}, 0);
        for (int k = 0; k < 12; k++) begin
            i = {$random(seed)} % ICC_NUM_EXT;
            v = ~ext_irq_in[i];
            if (v == c[i]) begin
                pq.push_back(32'h1 << i);
                st[i] = 1'b1;
            end
            u_far.set_pin(i, v);
        end
        bus(0, ICC_OFF_STATUS, 0, {27'h0, st});
        cmp_bit(|(st & m), irq);
        bus(1, ICC_OFF_STATUS, 32'h0000_001f, 0);
        bus(0, ICC_OFF_STATUS, 0, 0);
        cmp_bit(1'b0, irq);
    endtask : edges

    always @(posedge hclk) begin
        if (rd_pend && hreadyout === 1'b1) begin
            cmp(rq.size() ? rq.pop_front() : ~hrdata, hrdata);
            rd_pend = 1'b0;
        end
        if (hsel && hreadyout && htrans == ICC_HTRANS_NSQ && !hwrite) rd_pend = 1'b1;
        if (ext_irq_pend !== '0)
            cmp(pq.size() ? pq.pop_front() : '0, {27'h0, ext_irq_pend});
        if (prox_timer_start !== 1'b0)
            cmp_bit(xq.size() ? xq.pop_front() : 1'b0, prox_timer_start);
    end

    initial begin
        repeat (20000) @(posedge hclk);
        fails++;
        results();
    end

    initial begin
        logic [31:0] r;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        bus(0, ICC_OFF_CTRL, 0, ICC_CTRL_RST);
        bus(0, ICC_OFF_STATUS, 0, 0);
        bus(0, ICC_OFF_MASK, 0, 0);
        bus(1, ICC_OFF_CTRL, 32'hffff_ffff, 0);
        bus(0, ICC_OFF_CTRL, 0, 32'h0000_171f);
        cmp_bit(1'b1, vector_mode_select);
        bus(1, ICC_OFF_CTRL, 32'hffff_efff, 0);
        bus(0, ICC_OFF_CTRL, 0, 32'h0000_071f);
        cmp_bit(1'b0, vector_mode_select);
        for (int k = 0; k < 4; k++) begin
            r = $random(seed);
            bus(1, ICC_OFF_CTRL, r, 0);
            bus(0, ICC_OFF_CTRL, 0, r & 32'h0000_171f);
            cmp_bit(r[12], vector_mode_select);
        end
        bus(1, 32'h0000_0010, 32'hffff_ffff, 0);
        bus(0, 32'h0000_0010, 0, 0);
        bus(0, ICC_OFF_CTRL, 0, r & 32'h0000_171f);
        cmp_bit(ICC_HRESP_OKAY, hresp);
        for (int t = 0; t < 8; t++) begin
            bus(1, ICC_OFF_CTRL, 32'(t) << ICC_TPC_LSB, 0);
            for (int p = 0; p < 8; p++) begin
                if (t != 0 && p != 0 && p <= t) xq.push_back(1'b1);
                u_far.request(icc_prio_t'(p));
            end
        end
        r = $random(seed);
        edges(r, 5'h1f);
        edges(~r, r[4:0]);
        repeat (4) @(posedge hclk);
        cmp(0, pq.size() + xq.size() + rq.size());
        hresetn <= 1'b0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        bus(0, ICC_OFF_CTRL, 0, ICC_CTRL_RST);
        cmp_bit(1'b0, vector_mode_select);
        results();
    end
endmodule : testbench
